// *** rtl/crc_engine_regs.vh ***
// Register offsets, field positions, reset values and timing constants
// for the programmable CRC engine. Definitions only.
`ifndef CRC_ENGINE_REGS_VH
`define CRC_ENGINE_REGS_VH

// Byte offsets on the AXI4-Lite register bus
`define OFS_CRC_CONTROL      5'h00
`define OFS_FEEDBACK_POLY    5'h04
`define OFS_DATA_INPUT       5'h08
`define OFS_SHIFT_RESULT     5'h0C
`define OFS_POWER_STATE      5'h10

// Control register fields
`define CTL_STOP_IDLE        13
`define CTL_VWC_HI           12
`define CTL_VWC_LO           8
`define CTL_FULL             7
`define CTL_EMPTY            6
`define CTL_RUN              4
`define CTL_LEN_HI           3
`define CTL_LEN_LO           0
`define CTL_DONE_FLAG        14
`define CTL_DONE_EN          15

// Reset values
`define RST_CRC_CONTROL      16'h0040
`define RST_FEEDBACK_POLY    16'h0000
`define RST_DATA_INPUT       16'h0000
`define RST_SHIFT_RESULT     16'h0000

// Length codes
`define LEN_5BIT             4'h4
`define LEN_7BIT             4'h6
`define LEN_10BIT            4'h9
`define LEN_16BIT            4'hF

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

// Shift clock is twice the bus clock: two bits per aclk cycle
`define BITS_PER_CYCLE       2

`endif

// *** rtl/crc_shift_step.v ***
// One-bit MSb-first CRC reduction step for a selectable polynomial length.
// Assumes length-minus-one encoding of the length code.
`timescale 1ns/1ps
`default_nettype none

module crc_shift_step (
  input  wire [15:0] remainder_in,  // Remainder before this bit
  input  wire        data_bit,      // Message bit entering
  input  wire [15:0] poly,          // Coefficients, bit 0 implied one
  input  wire [3:0]  len_code,      // Length minus one
  output reg  [15:0] remainder_out  // Remainder after this bit
);

  reg        top_bit;   // Outgoing bit at the selected length
  reg [15:0] len_mask;  // Mask of valid remainder bits
  reg [15:0] shifted;   // Remainder moved up one place

  // Shift, feed message bit, fold polynomial when top bit was one
  always @* begin
    top_bit       = remainder_in[len_code];
    len_mask      = 16'hFFFF >> (4'hF - len_code);
    shifted       = {remainder_in[14:0], 1'b0};
    remainder_out = shifted ^ {15'h0000, data_bit};
    if (top_bit) begin
      remainder_out = remainder_out ^ {poly[15:1], 1'b1};
    end
    remainder_out = remainder_out & len_mask;
  end

endmodule // crc_shift_step

`default_nettype wire

// *** rtl/programmable_crc_engine.v ***
// Programmable CRC engine with 8-deep input FIFO and AXI4-Lite registers.
// Assumes one clock; power state is set by software in a register.
//
// What this block does
// - 5/7-bit lengths use low byte bits only
// - Code 04h selects 5, 06h selects 7
// - Code 0Fh selects 16, whole words
// - 10/12-bit lengths use low word bits
// - Code 09h selects 10-bit polynomial
// - Sleep freezes engine, resumes in place
// - Idle runs normally when stop bit clear
// - Idle with stop bit acts as Sleep
// - Control register layout, reset 0040
// - Polynomial bit 0 zero; other registers reset zero
// - Shift when run and count nonzero; flag
// - Write into full FIFO restarts it, except in a cycle that loads a word
// - Two bits per bus clock, MSb first
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_regs.vh"

module programmable_crc_engine #(
  parameter DEPTH = 8  // FIFO entries
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq
);

  // Configuration and state
  reg        stop_in_idle;      // Freeze in Idle when set
  reg        run_bit;           // Software start
  reg [3:0]  poly_length_code;  // Length minus one
  reg        done_irq_flag;     // Sticky completion flag
  reg        done_irq_enable;   // Gates flag onto irq
  reg [15:0] feedback_polynomial;
  reg [15:0] data_input_port;   // Last word written
  reg [15:0] shift_result;      // Remainder / checksum
  reg        sleep_mode;        // Power state: Sleep
  reg        idle_mode;         // Power state: Idle
  // FIFO storage, declared here as it is small and local
  reg [15:0] fifo_mem [0:DEPTH-1];
  reg [2:0]  wr_ptr;
  reg [2:0]  rd_ptr;
  reg [4:0]  valid_word_count;
  reg        fifo_full_flag;
  reg        fifo_empty_flag;
  // Shift engine
  reg [15:0] shreg;         // Word being shifted out
  reg [4:0]  bits_left;     // Bits of current word remaining
  reg        busy;          // Word loaded in engine
  // Bus slave staging
  reg        aw_held;
  reg [4:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire [15:0] ctrl_view;
  wire [15:0] in_mask;     // Data bits above the length count as zero
  wire [15:0] rem_mid;
  wire [15:0] rem_end;
  wire        frozen;
  wire        narrow;
  wire [4:0]  data_bits;
  wire        do_write;
  wire        wr_ctrl;
  wire        wr_poly;
  wire        wr_data;
  wire        wr_res;
  wire        wr_pwr;
  wire        load_word;
  wire        shifting;
  wire        last_step;

  // Merge a byte-strobed write onto a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  ws;
    begin
      merge16 = {ws[1] ? wd[15:8] : old[15:8],
                 ws[0] ? wd[7:0]  : old[7:0]};
    end
  endfunction

  // Control word as seen by software
  assign ctrl_view = {done_irq_enable, done_irq_flag, stop_in_idle,
                      valid_word_count, fifo_full_flag, fifo_empty_flag,
                      1'b0, run_bit, poly_length_code};
  // Sleep always freezes; Idle only when stop bit set
  assign frozen = sleep_mode | (idle_mode & stop_in_idle);
  // Short lengths take bytes; longer ones take words
  assign narrow = (poly_length_code < 4'h8);
  assign data_bits = narrow ? 5'd8 : 5'd16;
  assign in_mask = 16'hFFFF >> (4'hF - poly_length_code);

  // Write decode on the full address: misaligned writes have no effect
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_ctrl  = do_write & (aw_addr == `OFS_CRC_CONTROL);
  assign wr_poly  = do_write & (aw_addr == `OFS_FEEDBACK_POLY);
  assign wr_data  = do_write & (aw_addr == `OFS_DATA_INPUT);
  assign wr_res   = do_write & (aw_addr == `OFS_SHIFT_RESULT);
  assign wr_pwr   = do_write & (aw_addr == `OFS_POWER_STATE);
  // Start a word when running, idle engine, data present
  assign load_word = ~frozen & run_bit & ~busy &
                     (valid_word_count != 5'd0);
  assign shifting  = ~frozen & busy;
  assign last_step = shifting & (bits_left <= 5'd2);

  // Two reduction steps per clock: shift clock is double rate
  crc_shift_step u_step0 (
    .remainder_in  (shift_result),
    .data_bit      (shreg[15]),
    .poly          (feedback_polynomial),
    .len_code      (poly_length_code),
    .remainder_out (rem_mid)
  );
  crc_shift_step u_step1 (
    .remainder_in  (rem_mid),
    .data_bit      (shreg[14]),
    .poly          (feedback_polynomial),
    .len_code      (poly_length_code),
    .remainder_out (rem_end)
  );

  // AXI write address and data acceptance, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 5'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Response once both halves taken
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[4:2] > 3'd4 || aw_addr[1:0] != 2'b00) ?
                        `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel; data input reads as zero (write-only)
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr) // Misaligned reads fall to the refusal
          `OFS_CRC_CONTROL:   s_axi_rdata <= {16'h0000, ctrl_view};
          `OFS_FEEDBACK_POLY: s_axi_rdata <= {16'h0000, feedback_polynomial};
          `OFS_DATA_INPUT:    s_axi_rdata <= 32'h00000000;
          `OFS_SHIFT_RESULT:  s_axi_rdata <= {16'h0000, shift_result};
          `OFS_POWER_STATE:   s_axi_rdata <= {30'h0, idle_mode, sleep_mode};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      stop_in_idle        <= 1'b0;
      run_bit             <= 1'b0;
      poly_length_code    <= 4'h0;
      done_irq_enable     <= 1'b0;
      feedback_polynomial <= `RST_FEEDBACK_POLY;
      sleep_mode          <= 1'b0;
      idle_mode           <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        if (w_strb[0]) begin
          run_bit          <= w_data[`CTL_RUN];
          poly_length_code <= w_data[`CTL_LEN_HI:`CTL_LEN_LO];
        end
        if (w_strb[1]) begin
          stop_in_idle    <= w_data[`CTL_STOP_IDLE];
          done_irq_enable <= w_data[`CTL_DONE_EN];
        end
      end
      // Bit 0 is not stored and reads zero
      if (wr_poly) begin
        feedback_polynomial <= merge16(feedback_polynomial, w_data, w_strb)
                               & 16'hFFFE;
      end
      if (wr_pwr & w_strb[0]) begin
        sleep_mode <= w_data[0];
        idle_mode  <= w_data[1];
      end
    end
  end

  // FIFO pointers, count and flags; overflow write restarts FIFO unless a word loads that cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr           <= 3'd0;
      rd_ptr           <= 3'd0;
      valid_word_count <= 5'd0;
      fifo_full_flag   <= 1'b0;
      fifo_empty_flag  <= 1'b1;
      data_input_port  <= `RST_DATA_INPUT;
    end else begin
      if (wr_data & fifo_full_flag & ~load_word) begin
        fifo_mem[0]      <= merge16(data_input_port, w_data, w_strb);
        wr_ptr           <= 3'd1;
        rd_ptr           <= 3'd0;
        valid_word_count <= 5'd1;
        fifo_full_flag   <= 1'b0;
        fifo_empty_flag  <= 1'b0;
      end else begin
        if (wr_data) begin
          fifo_mem[wr_ptr] <= merge16(data_input_port, w_data, w_strb);
          wr_ptr           <= wr_ptr + 3'd1;
        end
        if (load_word) begin
          rd_ptr <= rd_ptr + 3'd1;
        end
        // Up on write, down on transfer
        case ({wr_data, load_word})
          2'b10: valid_word_count <= valid_word_count + 5'd1;
          2'b01: valid_word_count <= valid_word_count - 5'd1;
          default: valid_word_count <= valid_word_count;
        endcase
        fifo_full_flag <= (valid_word_count == DEPTH - 1) & wr_data
                          & ~load_word | fifo_full_flag & ~load_word;
        fifo_empty_flag <= (valid_word_count == 5'd1) & load_word
                           & ~wr_data | (fifo_empty_flag & ~wr_data);
      end
      if (wr_data) begin
        data_input_port <= merge16(data_input_port, w_data, w_strb);
      end
    end
  end

  // Shift engine: load word then reduce two bits per cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      shreg        <= 16'h0000;
      bits_left    <= 5'd0;
      busy         <= 1'b0;
      shift_result <= `RST_SHIFT_RESULT;
    end else begin
      if (load_word) begin
        // Left-align the low bits so the MSb of the word leaves first
        shreg     <= narrow ? {fifo_mem[rd_ptr][7:0] & in_mask[7:0], 8'h00}
                            : fifo_mem[rd_ptr] & in_mask;
        bits_left <= data_bits;
        busy      <= 1'b1;
      end else if (shifting) begin
        shreg        <= {shreg[13:0], 2'b00};
        shift_result <= rem_end;
        bits_left    <= bits_left - 5'd2;
        if (last_step) begin
          busy <= 1'b0;
        end
      end else if (wr_res & ~run_bit) begin
        // Direct preload only while stopped
        shift_result <= merge16(shift_result, w_data, w_strb);
      end
    end
  end

  // Done flag: count falls to zero; overflow restart never sets it
  always @(posedge aclk) begin
    if (!aresetn) begin
      done_irq_flag <= 1'b0;
      irq           <= 1'b0;
    end else begin
      // Set wins over a simultaneous software clear
      if (load_word & (valid_word_count == 5'd1) & ~wr_data) begin
        done_irq_flag <= 1'b1;
      end else if (wr_ctrl & w_strb[1] & ~w_data[`CTL_DONE_FLAG]) begin
        done_irq_flag <= 1'b0;
      end
      // Pending events still reach irq while frozen
      irq <= done_irq_flag & done_irq_enable;
    end
  end

endmodule // programmable_crc_engine

`default_nettype wire

// *** tb/crc_engine_checker.sv ***
// Bus and flag checker for the CRC engine top module.
// Assumes it is bound onto the engine and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_regs.vh"

module crc_engine_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write data handed over
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address handed over
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_aw_accepted: assert property (s_axi_awvalid && !s_axi_awready
    |-> ##[1:4] s_axi_awready) else $error("write address not taken");
  a_w_accepted: assert property (s_axi_wvalid && !s_axi_wready
    |-> ##[1:4] s_axi_wready) else $error("write data not taken");
  a_b_follows: assert property (w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_follows: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than a cycle");
  a_bad_read: assert property (ar_taken ##0 (s_axi_araddr > 5'h10)
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property ($rose(aresetn)
    |-> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy at reset");
endmodule // crc_engine_checker

bind programmable_crc_engine crc_engine_checker chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

// *** tb/crc_host_model.sv ***
// Register-bus master standing in for the CPU in front of the engine.
// Assumes the bench calls its tasks; waits end only by bench timeout.
`timescale 1ns/1ps
`default_nettype none

module crc_host_model (
  input  wire logic        aclk,
  output logic      [4:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [4:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h0;
  end

  // One write; both halves offered together, each dropped when taken
  task automatic wr(input [4:0] a, input [31:0] d, output [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h3; // Registers sit in the low half
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  // One read; rready held until the data is seen
  task automatic rd(input [4:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
endmodule // crc_host_model
`default_nettype wire

// *** tb/programmable_crc_engine_tb.sv ***
// Self-checking bench: checksums per length code, FIFO and power modes.
// Assumes the host model drives the register bus of the engine.
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_regs.vh"

module programmable_crc_engine_tb;
  logic        aclk, aresetn;
  wire  [4:0]  s_axi_awaddr, s_axi_araddr;
  wire  [31:0] s_axi_wdata, s_axi_rdata;
  wire  [3:0]  s_axi_wstrb;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire         s_axi_rvalid, s_axi_rready, irq;
  integer      n_fail = 0;
  integer      comparisons = 0;
  integer      cycles = 0;
  logic [15:0] dw [3] = '{16'hA5C3, 16'h3E7F, 16'h0000}; // Last is flush
  logic [3:0]  codes [5] = '{4'h4, 4'h6, 4'h7, 4'h9, 4'hF};

  programmable_crc_engine dut (.*);
  crc_host_model host (.*);

  // 40 MHz clock
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the run's several hundred cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task automatic chk(input string what, input [31:0] seen, exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input [4:0] a, input [15:0] d);
    logic [1:0] r;
    host.wr(a, {16'h0, d}, r);
    chk("write response", r, `RESP_OKAY);
  endtask

  task automatic rd(input [4:0] a, input [15:0] e, input string what);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(what, d, {16'h0, e});
  endtask

  // Augmented MSb-first division; unused upper data bits count as zero
  function automatic [15:0] crc_word(input [15:0] rem, w, p, input [3:0] c);
    integer i;
    logic o;
    logic [15:0] m;
    m = 16'hFFFF >> (15 - c);
    for (i = (c < 8) ? 7 : 15; i >= 0; i--) begin
      o = rem[c];
      rem = ((rem << 1) | ((i <= c) ? w[i] : 1'b0)) & m;
      if (o) rem = rem ^ ((p | 16'h1) & m);
    end
    return rem;
  endfunction

  // Full checksum run for one length code
  task automatic run_crc(input [3:0] c);
    logic [15:0] e;
    integer k;
    e = 16'h0;
    wr(`OFS_CRC_CONTROL, 16'h8000 | c);
    wr(`OFS_FEEDBACK_POLY, 16'hA6B5);
    wr(`OFS_SHIFT_RESULT, 16'h0000);
    for (k = 0; k < 3; k++) begin
      wr(`OFS_DATA_INPUT, dw[k]);
      e = crc_word(e, dw[k], 16'hA6B5, c);
    end
    rd(`OFS_CRC_CONTROL, 16'h8300 | c, "queued words");
    wr(`OFS_CRC_CONTROL, 16'h8010 | c);
    for (k = 0; k < 300 && !irq; k++) @(posedge aclk);
    chk("irq", irq, 1);
    rd(`OFS_CRC_CONTROL, 16'hC050 | c, "drained");
    wr(`OFS_CRC_CONTROL, {12'h0, c});
    @(posedge aclk); // irq follows the cleared flag one cycle later
    chk("irq cleared", irq, 0);
    rd(`OFS_SHIFT_RESULT, e, "checksum");
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(`OFS_CRC_CONTROL, 16'h0040, "control reset");
    rd(`OFS_FEEDBACK_POLY, 16'h0000, "poly reset");
    rd(`OFS_SHIFT_RESULT, 16'h0000, "result reset");
    rd(`OFS_DATA_INPUT, 16'h0000, "data input");
    wr(`OFS_FEEDBACK_POLY, 16'hFFFF);
    rd(`OFS_FEEDBACK_POLY, 16'hFFFE, "poly bit zero");
    host.rd(5'h14, d, r);
    chk("unmapped response", r, `RESP_SLVERR);
    chk("unmapped data", d, 0);
    foreach (codes[i]) run_crc(codes[i]);
    // Fill to full, then one more write restarts the queue
    for (int i = 0; i < 8; i++) wr(`OFS_DATA_INPUT, 16'h1111 * i);
    rd(`OFS_CRC_CONTROL, 16'h088F, "fifo full");
    wr(`OFS_DATA_INPUT, 16'h5A5A);
    rd(`OFS_CRC_CONTROL, 16'h010F, "fifo restart");
    // Sleep holds the queued word, wake lets it drain
    wr(`OFS_POWER_STATE, 16'h0001);
    wr(`OFS_CRC_CONTROL, 16'h001F);
    repeat (20) @(posedge aclk);
    rd(`OFS_CRC_CONTROL, 16'h011F, "sleep frozen");
    wr(`OFS_POWER_STATE, 16'h0000);
    repeat (20) @(posedge aclk);
    rd(`OFS_CRC_CONTROL, 16'h405F, "resumed");
    // Idle freezes only with the stop bit set
    wr(`OFS_CRC_CONTROL, 16'h200F);
    wr(`OFS_DATA_INPUT, 16'h0001);
    wr(`OFS_POWER_STATE, 16'h0002);
    wr(`OFS_CRC_CONTROL, 16'h201F);
    repeat (20) @(posedge aclk);
    rd(`OFS_CRC_CONTROL, 16'h211F, "idle stopped");
    wr(`OFS_CRC_CONTROL, 16'h001F);
    repeat (20) @(posedge aclk);
    rd(`OFS_CRC_CONTROL, 16'h405F, "idle running");
    wr(`OFS_POWER_STATE, 16'h0000);
    complete_run;
  end
endmodule // programmable_crc_engine_tb
`default_nettype wire
